// >>> verilog/perf_state_pkg.sv
// Shared constants and types for the performance-state control block
package perf_state_pkg;

    // Data widths
    localparam int DATA_W = 64;
    localparam int ADDR_W = 32;
    localparam int OP_W   = 16;
    localparam int ID_W   = 32;

    // Model register addresses
    localparam logic [ADDR_W-1:0] ADDR_FIXED_COUNT  = 32'h0000_00e7;
    localparam logic [ADDR_W-1:0] ADDR_ACTUAL_COUNT = 32'h0000_00e8;
    localparam logic [ADDR_W-1:0] ADDR_OP_REQUEST   = 32'h0000_0010;
    localparam logic [ADDR_W-1:0] ADDR_OP_CURRENT   = 32'h0000_0011;
    localparam logic [ADDR_W-1:0] ADDR_MISC_ENABLES = 32'h0000_0012;

    // Field positions
    localparam int MISC_TRANSITION_EN_BIT = 16;
    localparam int ID_ECX_TRANSITION_BIT  = 7;
    localparam int ID_ECX_FEEDBACK_BIT    = 0;

    // Identification leaves
    localparam logic [ID_W-1:0] LEAF_FEATURES    = 32'h0000_0001;
    localparam logic [ID_W-1:0] LEAF_POWER_MGMT  = 32'h0000_0006;

    // Reset values
    localparam logic [DATA_W-1:0] COUNT_RESET    = 64'h0000_0000_0000_0000;
    localparam logic [OP_W-1:0]   OP_CODE_RESET  = 16'h0000;
    localparam logic [ID_W-1:0]   ID_ZERO        = 32'h0000_0000;

    // Operating-point stepper states
    typedef enum logic {
        STEP_IDLE,
        STEP_MOVING
    } step_state_type;

endpackage

// >>> verilog/feedback_counter.sv
// One 64-bit feedback counter with write, increment and joint clear
`timescale 1ns/1ns
module feedback_counter (
    input  logic                              clock,
    input  logic                              rst_n,
    input  logic                              inc,
    input  logic                              clear_all,
    input  logic                              wr,
    input  logic [perf_state_pkg::DATA_W-1:0] wdata,
    output logic [perf_state_pkg::DATA_W-1:0] count,
    output logic                              wrap
);
    logic [perf_state_pkg::DATA_W-1:0] count_reg;
    logic [perf_state_pkg::DATA_W-1:0] count_next;

    // Carry out of the top bit on this increment
    assign wrap  = inc && (&count_reg);
    assign count = count_reg;

    // Software write wins, then joint clear, then counting
    always_comb begin
        count_next = count_reg;
        if (wr) begin
            count_next = wdata; // R14
        end else if (clear_all) begin
            count_next = perf_state_pkg::COUNT_RESET; // R13
        end else if (inc) begin
            count_next = count_reg + 64'h1;
        end
    end

    // Counter register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= perf_state_pkg::COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// >>> verilog/op_point_stepper.sv
// Sequencer that steps the operating point to the latest requested code
`timescale 1ns/1ns
module op_point_stepper (
    input  logic                            clock,
    input  logic                            rst_n,
    input  logic                            enable,
    input  logic                            req_write,
    input  logic [perf_state_pkg::OP_W-1:0] req_code,
    input  logic                            step_done,
    output logic [perf_state_pkg::OP_W-1:0] step_code,
    output logic                            step_start,
    output logic [perf_state_pkg::OP_W-1:0] current_code,
    output logic                            transition_event,
    output logic                            busy,
    output logic                            pending
);
    perf_state_pkg::step_state_type state_reg, state_next;
    logic                            pending_reg, pending_next;
    logic [perf_state_pkg::OP_W-1:0] pend_code_reg, pend_code_next;
    logic [perf_state_pkg::OP_W-1:0] step_code_reg, step_code_next;
    logic [perf_state_pkg::OP_W-1:0] current_reg, current_next;
    logic                            start_reg, start_next;
    logic                            event_reg, event_next;

    // Next-state logic of the stepper
    always_comb begin
        state_next     = state_reg;
        pending_next   = pending_reg;
        pend_code_next = pend_code_reg;
        step_code_next = step_code_reg;
        current_next   = current_reg;
        start_next     = 1'b0;
        event_next     = 1'b0;
        case (state_reg)
            perf_state_pkg::STEP_IDLE: begin
                if (enable && pending_reg) begin // R2
                    step_code_next = pend_code_reg; // R8
                    start_next     = 1'b1; // R3
                    pending_next   = 1'b0;
                    state_next     = perf_state_pkg::STEP_MOVING;
                end
            end
            perf_state_pkg::STEP_MOVING: begin
                if (step_done) begin
                    current_next = step_code_reg; // R21
                    event_next   = 1'b1; // R20
                    state_next   = perf_state_pkg::STEP_IDLE;
                end
            end
            default: begin
                state_next = perf_state_pkg::STEP_IDLE;
            end
        endcase
        // A new request is kept even mid-step; it wins over the take
        if (req_write) begin
            pending_next   = 1'b1; // R4
            pend_code_next = req_code;
        end
    end

    // Stepper registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= perf_state_pkg::STEP_IDLE;
            pending_reg   <= 1'b0;
            pend_code_reg <= perf_state_pkg::OP_CODE_RESET;
            step_code_reg <= perf_state_pkg::OP_CODE_RESET;
            current_reg   <= perf_state_pkg::OP_CODE_RESET;
            start_reg     <= 1'b0;
            event_reg     <= 1'b0;
        end else begin
            state_reg     <= state_next;
            pending_reg   <= pending_next;
            pend_code_reg <= pend_code_next;
            step_code_reg <= step_code_next;
            current_reg   <= current_next;
            start_reg     <= start_next;
            event_reg     <= event_next;
        end
    end

    assign step_code        = step_code_reg;
    assign step_start       = start_reg;
    assign current_code     = current_reg;
    assign transition_event = event_reg;
    assign busy             = (state_reg == perf_state_pkg::STEP_MOVING);
    assign pending          = pending_reg;
endmodule

// >>> verilog/perf_state_ctrl.sv
// Per-processor performance-state request, status and feedback counters
`timescale 1ns/1ns
// Notes on behaviour
// [R1] Feature query reports transition support, ECX bit 7
// [R2] Transitions run only while enable bit 16 set
// [R3] Writing request code starts a transition
// [R4] Request written mid-transition is kept, applied after
// [R5] Request register reads back last requested code
// [R6] Separate read-only status shows code in effect
// [R7] Code meaning is implementation defined, passed through
// [R8] Each change is one discrete step
// [R9] Leaf six ECX bit 0 reports counters
// [R10] Fixed-rate counter advances on reference ticks
// [R11] Actual-rate counter advances with delivered performance
// [R12] Counters are per processor, count only in C0
// [R13] Either overflow clears both counters to zero
// [R14] Full 64-bit counters, written independently
// [R15] Software uses only the counter ratio
// [R16] Software records or zeroes both per window
// [R17] Software detects overflow by smaller reread value
// [R18] Software checks capability before using the ratio
// [R19] Applications leave request and status registers alone
// [R20] Transition events are counted by monitoring outputs
// [R21] Status changes only when a step completes
module perf_state_ctrl (
    input  logic                              clock,
    input  logic                              rst_n,
    input  logic [perf_state_pkg::ADDR_W-1:0] reg_addr,
    input  logic [perf_state_pkg::DATA_W-1:0] reg_wdata,
    input  logic                              reg_write,
    input  logic                              reg_read,
    output logic [perf_state_pkg::DATA_W-1:0] reg_rdata,
    output logic                              reg_rvalid,
    input  logic                              id_query,
    input  logic [perf_state_pkg::ID_W-1:0]   id_leaf,
    output logic [perf_state_pkg::ID_W-1:0]   id_ecx,
    output logic                              id_valid,
    input  logic                              c0_active,
    input  logic                              ref_tick,
    input  logic                              perf_tick,
    input  logic                              step_done,
    output logic [perf_state_pkg::OP_W-1:0]   step_code,
    output logic                              step_start,
    output logic                              transition_event
);
    // Register file state
    logic [perf_state_pkg::OP_W-1:0]   request_reg, request_next;
    logic                              trans_en_reg, trans_en_next;
    logic [perf_state_pkg::DATA_W-1:0] rdata_reg, rdata_next;
    logic                              rvalid_reg, rvalid_next;
    logic [perf_state_pkg::ID_W-1:0]   ecx_reg, ecx_next;
    logic                              id_valid_reg, id_valid_next;

    // Decoded strobes and internal wires
    logic                              wr_request;
    logic                              wr_misc;
    logic                              wr_fixed;
    logic                              wr_actual;
    logic                              inc_fixed;
    logic                              inc_actual;
    logic                              wrap_fixed;
    logic                              wrap_actual;
    logic                              clear_both;
    logic [perf_state_pkg::DATA_W-1:0] fixed_count;
    logic [perf_state_pkg::DATA_W-1:0] actual_count;
    logic [perf_state_pkg::OP_W-1:0]   current_code;
    logic                              busy;
    logic                              pending;

    // Address match used by every decode
    function automatic logic addr_is(input logic [perf_state_pkg::ADDR_W-1:0] a,
                                     input logic [perf_state_pkg::ADDR_W-1:0] b);
        addr_is = (a == b);
    endfunction

    // Write strobes
    assign wr_request = reg_write && addr_is(reg_addr, perf_state_pkg::ADDR_OP_REQUEST);
    assign wr_misc    = reg_write && addr_is(reg_addr, perf_state_pkg::ADDR_MISC_ENABLES);
    assign wr_fixed   = reg_write && addr_is(reg_addr, perf_state_pkg::ADDR_FIXED_COUNT);
    assign wr_actual  = reg_write && addr_is(reg_addr, perf_state_pkg::ADDR_ACTUAL_COUNT);

    // Counting only in the active state
    assign inc_fixed  = c0_active && ref_tick; // R10 R12
    assign inc_actual = c0_active && perf_tick; // R11 R12
    assign clear_both = wrap_fixed || wrap_actual; // R13

    // Fixed-rate feedback counter
    feedback_counter u_fixed (
        .clock     (clock),
        .rst_n     (rst_n),
        .inc       (inc_fixed),
        .clear_all (clear_both),
        .wr        (wr_fixed),
        .wdata     (reg_wdata),
        .count     (fixed_count),
        .wrap      (wrap_fixed)
    );

    // Actual-rate feedback counter
    feedback_counter u_actual (
        .clock     (clock),
        .rst_n     (rst_n),
        .inc       (inc_actual),
        .clear_all (clear_both),
        .wr        (wr_actual),
        .wdata     (reg_wdata),
        .count     (actual_count),
        .wrap      (wrap_actual)
    );

    // Operating-point stepper; codes pass through unchanged
    op_point_stepper u_stepper (
        .clock            (clock),
        .rst_n            (rst_n),
        .enable           (trans_en_reg),
        .req_write        (wr_request),
        .req_code         (reg_wdata[perf_state_pkg::OP_W-1:0]), // R7
        .step_done        (step_done),
        .step_code        (step_code),
        .step_start       (step_start),
        .current_code     (current_code),
        .transition_event (transition_event),
        .busy             (busy),
        .pending          (pending)
    );

    // Register writes, reads and identification answers
    always_comb begin
        request_next  = request_reg;
        trans_en_next = trans_en_reg;
        rdata_next    = rdata_reg;
        rvalid_next   = reg_read;
        ecx_next      = ecx_reg;
        id_valid_next = id_query;
        if (wr_request) begin
            request_next = reg_wdata[perf_state_pkg::OP_W-1:0]; // R3
        end
        if (wr_misc) begin
            trans_en_next = reg_wdata[perf_state_pkg::MISC_TRANSITION_EN_BIT]; // R2
        end
        if (reg_read) begin
            rdata_next = '0;
            if (addr_is(reg_addr, perf_state_pkg::ADDR_OP_REQUEST)) begin
                rdata_next[perf_state_pkg::OP_W-1:0] = request_reg; // R5
            end else if (addr_is(reg_addr, perf_state_pkg::ADDR_OP_CURRENT)) begin
                rdata_next[perf_state_pkg::OP_W-1:0] = current_code; // R6
            end else if (addr_is(reg_addr, perf_state_pkg::ADDR_MISC_ENABLES)) begin
                rdata_next[perf_state_pkg::MISC_TRANSITION_EN_BIT] = trans_en_reg;
            end else if (addr_is(reg_addr, perf_state_pkg::ADDR_FIXED_COUNT)) begin
                rdata_next = fixed_count;
            end else if (addr_is(reg_addr, perf_state_pkg::ADDR_ACTUAL_COUNT)) begin
                rdata_next = actual_count;
            end
        end
        if (id_query) begin
            ecx_next = perf_state_pkg::ID_ZERO;
            if (id_leaf == perf_state_pkg::LEAF_FEATURES) begin
                ecx_next[perf_state_pkg::ID_ECX_TRANSITION_BIT] = 1'b1; // R1
            end else if (id_leaf == perf_state_pkg::LEAF_POWER_MGMT) begin
                ecx_next[perf_state_pkg::ID_ECX_FEEDBACK_BIT] = 1'b1; // R9
            end
        end
    end

    // Register file flops; enable bit clears on reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            request_reg  <= perf_state_pkg::OP_CODE_RESET;
            trans_en_reg <= 1'b0; // R2
            rdata_reg    <= perf_state_pkg::COUNT_RESET;
            rvalid_reg   <= 1'b0;
            ecx_reg      <= perf_state_pkg::ID_ZERO;
            id_valid_reg <= 1'b0;
        end else begin
            request_reg  <= request_next;
            trans_en_reg <= trans_en_next;
            rdata_reg    <= rdata_next;
            rvalid_reg   <= rvalid_next;
            ecx_reg      <= ecx_next;
            id_valid_reg <= id_valid_next;
        end
    end

    assign reg_rdata  = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign id_ecx     = ecx_reg;
    assign id_valid   = id_valid_reg;

    // Checks on the behaviour above
    property p_feature_flag;
        @(posedge clock) disable iff (!rst_n)
        (id_query && id_leaf == perf_state_pkg::LEAF_FEATURES)
            |=> id_valid && id_ecx[perf_state_pkg::ID_ECX_TRANSITION_BIT];
    endproperty
    a_feature_flag: assert property (p_feature_flag) // R1
        else $error("transition support flag missing");

    property p_counter_flag;
        @(posedge clock) disable iff (!rst_n)
        (id_query && id_leaf == perf_state_pkg::LEAF_POWER_MGMT)
            |=> id_ecx[perf_state_pkg::ID_ECX_FEEDBACK_BIT];
    endproperty
    a_counter_flag: assert property (p_counter_flag) // R9
        else $error("feedback counter flag missing");

    property p_enable_gate;
        @(posedge clock) disable iff (!rst_n)
        step_start |-> $past(trans_en_reg);
    endproperty
    a_enable_gate: assert property (p_enable_gate) // R2
        else $error("step started while transitions disabled");

    property p_write_starts;
        @(posedge clock) disable iff (!rst_n)
        (wr_request && trans_en_reg && !busy && !pending && !wr_misc)
            |-> ##2 (step_start && step_code == $past(reg_wdata[perf_state_pkg::OP_W-1:0], 2));
    endproperty
    a_write_starts: assert property (p_write_starts) // R3
        else $error("request write did not start a step");

    property p_keep_late;
        @(posedge clock) disable iff (!rst_n)
        (wr_request && busy) |=> pending;
    endproperty
    a_keep_late: assert property (p_keep_late) // R4
        else $error("request during step was lost");

    property p_readback;
        @(posedge clock) disable iff (!rst_n)
        wr_request ##1 (reg_read && addr_is(reg_addr, perf_state_pkg::ADDR_OP_REQUEST)
            && !wr_request)
            |=> reg_rvalid
            && reg_rdata[perf_state_pkg::OP_W-1:0] == $past(reg_wdata[perf_state_pkg::OP_W-1:0], 2);
    endproperty
    a_readback: assert property (p_readback) // R5
        else $error("request readback differs from last write");

    property p_status_on_done;
        @(posedge clock) disable iff (!rst_n)
        !$stable(current_code) |-> $past(step_done && busy) && transition_event;
    endproperty
    a_status_on_done: assert property (p_status_on_done) // R21 R20
        else $error("status changed without a completed step");

    property p_fixed_counts;
        @(posedge clock) disable iff (!rst_n)
        (inc_fixed && !wr_fixed && !clear_both) |=> fixed_count == $past(fixed_count) + 64'h1;
    endproperty
    a_fixed_counts: assert property (p_fixed_counts) // R10
        else $error("fixed-rate counter did not advance");

    property p_idle_hold;
        @(posedge clock) disable iff (!rst_n)
        (!c0_active && !wr_fixed && !wr_actual)
            |=> $stable(fixed_count) && $stable(actual_count);
    endproperty
    a_idle_hold: assert property (p_idle_hold) // R12
        else $error("counter moved outside the active state");

    property p_joint_clear;
        @(posedge clock) disable iff (!rst_n)
        (clear_both && !wr_fixed && !wr_actual)
            |=> fixed_count == 64'h0 && actual_count == 64'h0;
    endproperty
    a_joint_clear: assert property (p_joint_clear) // R13
        else $error("overflow did not clear both counters");

    property p_independent;
        @(posedge clock) disable iff (!rst_n)
        (wr_fixed && !inc_actual && !clear_both)
            |=> actual_count == $past(actual_count) && fixed_count == $past(reg_wdata);
    endproperty
    a_independent: assert property (p_independent) // R14
        else $error("counter write disturbed the other counter");

    property p_actual_counts;
        @(posedge clock) disable iff (!rst_n)
        (inc_actual && !wr_actual && !clear_both)
            |=> actual_count == $past(actual_count) + 64'h1;
    endproperty
    a_actual_counts: assert property (p_actual_counts) // R11
        else $error("actual-rate counter did not advance");

    property p_status_read;
        @(posedge clock) disable iff (!rst_n)
        (reg_read && addr_is(reg_addr, perf_state_pkg::ADDR_OP_CURRENT))
            |=> reg_rvalid && reg_rdata[perf_state_pkg::OP_W-1:0] == $past(current_code)
            && reg_rdata[perf_state_pkg::DATA_W-1:perf_state_pkg::OP_W] == '0;
    endproperty
    a_status_read: assert property (p_status_read) // R6
        else $error("status read differs from code in effect");

    property p_one_step;
        @(posedge clock) disable iff (!rst_n)
        step_start |-> busy && !$past(busy);
    endproperty
    a_one_step: assert property (p_one_step) // R8
        else $error("step started while another was running");

    property p_done_idle;
        @(posedge clock) disable iff (!rst_n)
        (step_done && !busy) |=> $stable(current_code) && !transition_event;
    endproperty
    a_done_idle: assert property (p_done_idle) // R21
        else $error("completion while idle changed the status");

    property p_misc_read;
        @(posedge clock) disable iff (!rst_n)
        (reg_read && addr_is(reg_addr, perf_state_pkg::ADDR_MISC_ENABLES))
            |=> reg_rdata[perf_state_pkg::MISC_TRANSITION_EN_BIT] == $past(trans_en_reg);
    endproperty
    a_misc_read: assert property (p_misc_read) // R2
        else $error("enable bit readback differs");
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the performance-state control block
`timescale 1ns/1ns
module testbench;
    localparam int D = 1;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [63:0] reg_wdata = 64'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [63:0] reg_rdata;
    logic        reg_rvalid;
    logic        id_query = 1'b0;
    logic [31:0] id_leaf = 32'h0;
    logic [31:0] id_ecx;
    logic        id_valid;
    logic        c0_active = 1'b0;
    logic        ref_tick = 1'b0;
    logic        perf_tick = 1'b0;
    logic        step_done = 1'b0;
    logic [15:0] step_code;
    logic        step_start;
    logic        transition_event;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [63:0] rd;

    perf_state_ctrl DUT (
        .clock            (clock),
        .rst_n            (rst_n),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_write        (reg_write),
        .reg_read         (reg_read),
        .reg_rdata        (reg_rdata),
        .reg_rvalid       (reg_rvalid),
        .id_query         (id_query),
        .id_leaf          (id_leaf),
        .id_ecx           (id_ecx),
        .id_valid         (id_valid),
        .c0_active        (c0_active),
        .ref_tick         (ref_tick),
        .perf_tick        (perf_tick),
        .step_done        (step_done),
        .step_code        (step_code),
        .step_start       (step_start),
        .transition_event (transition_event)
    );

    // Clock and hang guard
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One register write strobe
    task automatic reg_wr(input logic [31:0] a, input logic [63:0] d);
        @(posedge clock) #D;
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clock) #D;
        reg_write = 1'b0;
    endtask

    // Read strobe, then bounded wait for the data pulse
    task automatic reg_rd_check(input logic [31:0] a, input logic [63:0] exp);
        int k;
        @(posedge clock) #D;
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge clock) #D;
        reg_read = 1'b0;
        for (k = 0; k < 3 && reg_rvalid !== 1'b1; k++) begin
            @(posedge clock) #D;
        end
        check({63'h0, reg_rvalid}, 64'h1);
        check(reg_rdata, exp);
    endtask

    task automatic id_check(input logic [31:0] leaf, input logic [31:0] exp);
        int k;
        @(posedge clock) #D;
        id_leaf = leaf;
        id_query = 1'b1;
        @(posedge clock) #D;
        id_query = 1'b0;
        for (k = 0; k < 3 && id_valid !== 1'b1; k++) begin
            @(posedge clock) #D;
        end
        check({63'h0, id_valid}, 64'h1);
        check({32'h0, id_ecx}, {32'h0, exp});
    endtask

    // Bounded wait for a step start carrying the given code
    task automatic wait_start(input logic [15:0] code);
        int k;
        for (k = 0; k < 10 && step_start !== 1'b1; k++) begin
            @(posedge clock) #D;
        end
        check({63'h0, step_start}, 64'h1);
        check({48'h0, step_code}, {48'h0, code});
    endtask

    // Finish the running step and wait for its completion pulse
    task automatic finish_step();
        int k;
        @(posedge clock) #D;
        step_done = 1'b1;
        @(posedge clock) #D;
        step_done = 1'b0;
        for (k = 0; k < 3 && transition_event !== 1'b1; k++) begin
            @(posedge clock) #D;
        end
        check({63'h0, transition_event}, 64'h1);
    endtask

    task automatic test_reset_and_id();
        reg_rd_check(perf_state_pkg::ADDR_MISC_ENABLES, 64'h0);
        reg_rd_check(perf_state_pkg::ADDR_FIXED_COUNT, 64'h0);
        reg_rd_check(perf_state_pkg::ADDR_OP_CURRENT, 64'h0);
        reg_rd_check(32'h0000_0077, 64'h0);
        id_check(perf_state_pkg::LEAF_FEATURES, 32'h0000_0080);
        id_check(perf_state_pkg::LEAF_POWER_MGMT, 32'h0000_0001);
        id_check(32'h0000_0003, 32'h0);
    endtask

    task automatic test_transitions();
        int k;
        reg_wr(perf_state_pkg::ADDR_OP_REQUEST, 64'h0000_0000_0000_1a2b);
        reg_rd_check(perf_state_pkg::ADDR_OP_REQUEST, 64'h1a2b);
        // Disabled: no step may start
        for (k = 0; k < 6; k++) begin
            @(posedge clock) #D;
            check({63'h0, step_start}, 64'h0);
        end
        reg_wr(perf_state_pkg::ADDR_MISC_ENABLES, 64'h0000_0000_0001_0000);
        wait_start(16'h1a2b);
        reg_wr(perf_state_pkg::ADDR_OP_REQUEST, 64'h0000_0000_0000_3c4d);
        reg_rd_check(perf_state_pkg::ADDR_OP_REQUEST, 64'h3c4d);
        reg_rd_check(perf_state_pkg::ADDR_OP_CURRENT, 64'h0);
        reg_wr(perf_state_pkg::ADDR_OP_CURRENT, 64'h0000_0000_0000_5555);
        finish_step();
        wait_start(16'h3c4d);
        reg_rd_check(perf_state_pkg::ADDR_OP_CURRENT, 64'h1a2b);
        finish_step();
        // Completion pulse while idle is ignored
        @(posedge clock) #D;
        step_done = 1'b1;
        @(posedge clock) #D;
        step_done = 1'b0;
        check({63'h0, transition_event}, 64'h0);
        reg_rd_check(perf_state_pkg::ADDR_OP_CURRENT, 64'h3c4d);
    endtask

    task automatic test_counters();
        reg_wr(perf_state_pkg::ADDR_FIXED_COUNT, 64'h0);
        reg_wr(perf_state_pkg::ADDR_ACTUAL_COUNT, 64'h0000_0000_0000_0100);
        reg_rd_check(perf_state_pkg::ADDR_FIXED_COUNT, 64'h0);
        @(posedge clock) #D;
        c0_active = 1'b1;
        ref_tick = 1'b1;
        perf_tick = 1'b1;
        @(posedge clock) #D;
        @(posedge clock) #D;
        perf_tick = 1'b0;
        @(posedge clock) #D;
        ref_tick = 1'b0;
        c0_active = 1'b0;
        reg_rd_check(perf_state_pkg::ADDR_FIXED_COUNT, 64'h3);
        reg_rd_check(perf_state_pkg::ADDR_ACTUAL_COUNT, 64'h102);
        // Ticks outside the active state
        ref_tick = 1'b1;
        perf_tick = 1'b1;
        @(posedge clock) #D;
        @(posedge clock) #D;
        ref_tick = 1'b0;
        perf_tick = 1'b0;
        reg_rd_check(perf_state_pkg::ADDR_FIXED_COUNT, 64'h3);
        reg_rd_check(perf_state_pkg::ADDR_ACTUAL_COUNT, 64'h102);
        // Overflow of one clears both
        reg_wr(perf_state_pkg::ADDR_FIXED_COUNT, 64'hffff_ffff_ffff_ffff);
        @(posedge clock) #D;
        c0_active = 1'b1;
        ref_tick = 1'b1;
        @(posedge clock) #D;
        ref_tick = 1'b0;
        repeat (3) @(posedge clock);
        #D;
        reg_rd_check(perf_state_pkg::ADDR_FIXED_COUNT, 64'h0);
        rd = reg_rdata;
        check({63'h0, rd < 64'hffff_ffff_ffff_ffff}, 64'h1);
        reg_rd_check(perf_state_pkg::ADDR_ACTUAL_COUNT, 64'h0);
        perf_tick = 1'b1;
        @(posedge clock) #D;
        perf_tick = 1'b0;
        c0_active = 1'b0;
        reg_rd_check(perf_state_pkg::ADDR_ACTUAL_COUNT, 64'h1);
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        #D;
        rst_n = 1'b1;
        test_reset_and_id();
        test_transitions();
        test_counters();
        test_done();
    end
endmodule
